/* File: core/cmrs_pkg.sv */
// Constants, types and decode functions for the channel mux and relay sequencer
package cmrs_pkg;

  // Clock and timing, times in ns
  localparam int CLK_MHZ       = 100;
  localparam int T_REED_NS     = 1000000;
  localparam int T_SS_SEL_NS   = 150000;
  localparam int T_SS_DES_NS   = 120000;
  localparam int T_COIL_NS     = 6000000;
  // Least times, so round up to whole cycles
  localparam int REED_CYC      = (T_REED_NS * CLK_MHZ + 999) / 1000;
  localparam int SS_SEL_CYC    = (T_SS_SEL_NS * CLK_MHZ + 999) / 1000;
  localparam int SS_DES_CYC    = (T_SS_DES_NS * CLK_MHZ + 999) / 1000;
  localparam int COIL_CYC      = (T_COIL_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W         = 20;

  // Register byte offsets
  localparam logic [7:0] A_CMD  = 8'h00;
  localparam logic [7:0] A_COIL = 8'h04;
  localparam logic [7:0] A_CFG  = 8'h08;
  localparam logic [7:0] A_STAT = 8'h0c;
  localparam logic [7:0] A_OUT  = 8'h10;

  // Field positions
  localparam int CFG_SS_BIT    = 0;
  localparam int ST_BUSY       = 0;
  localparam int ST_CONFLICT   = 1;
  localparam int ST_BADCHAN    = 2;
  localparam int ST_REFUSED    = 3;

  // Pin patterns and reset values
  localparam logic [2:0] TREE_LO    = 3'h5;
  localparam logic [2:0] TREE_HI    = 3'h6;
  localparam logic [2:0] TREE_HV_LO = 3'h1;
  localparam logic [2:0] TREE_HV_HI = 3'h2;
  localparam logic [2:0] TREE_4W    = 3'h7;
  localparam logic [2:0] TREE_OFF   = 3'h0;
  localparam logic [2:0] TREE_RST   = TREE_LO;
  localparam logic [3:0] CHAN_NONE  = 4'hf;
  localparam logic [3:0] CHAN_MAX   = 4'h9;
  localparam logic [5:0] COIL_OFF   = 6'h00;
  localparam logic [5:0] COIL_DC    = 6'h16;
  localparam logic [5:0] COIL_RES   = 6'h26;
  localparam logic [5:0] COIL_AC    = 6'h19;

  typedef enum logic [2:0] {
    FN_VDC_LO, FN_VDC_HI, FN_VAC, FN_FREQ, FN_RES2W, FN_RES4W, FN_TC, FN_OTC
  } cmrs_func_e;

  typedef struct packed {
    cmrs_func_e func;
    logic       bank;
    logic [3:0] chan;
  } cmrs_cmd_s;

  typedef struct packed {
    logic [2:0] tree;
    logic [3:0] chan;
    logic [5:0] coil;
  } cmrs_pins_s;

  function automatic logic [2:0] tree_of(cmrs_func_e f, logic bank);
    if (f == FN_RES4W) return TREE_4W;
    if (f == FN_VDC_HI) return bank ? TREE_HV_HI : TREE_HV_LO;
    return bank ? TREE_HI : TREE_LO;
  endfunction

  function automatic logic [5:0] coil_of(cmrs_func_e f);
    if (f == FN_RES2W || f == FN_RES4W) return COIL_RES;
    if (f == FN_VAC || f == FN_FREQ) return COIL_AC;
    return COIL_DC;
  endfunction

  // Set and reset coil of one relay sit in bits 2k and 2k+1
  function automatic logic clash(logic [5:0] c);
    logic hit;
    hit = 1'b0;
    for (int k = 0; k < 3; k++) begin
      hit = hit | (c[2*k] & c[2*k+1]);
    end
    return hit;
  endfunction

endpackage

/* File: core/cmrs_top.sv */
// Channel mux and function relay sequencer with AHB-Lite register slave
// Notes on behaviour
// - Tree bits pick bank zero for channels 1-10, bank one for 11-20.
// - Tree 101/110 for low-level functions, 001/010 dc above 3 V, 111 four-wire.
// - Four-wire resistance closes low-bank and high-bank tree switches together.
// - Channel bits hold binary index 0000 to 1001 within the bank.
// - Writing 1111 to the channel bits leaves every channel unselected.
// - Tree bits are never driven to a deselected pattern.
// - New channel may be selected in the same write that deselects the old.
// - Wait 1 ms reed, or 150/120 us solid-state, after switch changes.
// - Relay change is a coil pulse then a clear, 6 ms apart.
// - After 6 ms the six coil bits are written 000000.
// - Set and reset coil of one relay are never on together.
// - Coil patterns 011010 dc/thermocouple, 011001 resistance, 100110 ac/frequency; the code drives 010110 dc/thermocouple, 100110 resistance, 011001 ac/frequency.
//
// The implementer's own choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps

module cmrs_top #(
  parameter int REED_CYC   = cmrs_pkg::REED_CYC,
  parameter int SS_SEL_CYC = cmrs_pkg::SS_SEL_CYC,
  parameter int SS_DES_CYC = cmrs_pkg::SS_DES_CYC,
  parameter int COIL_CYC   = cmrs_pkg::COIL_CYC
) (
  // Clock, reset, enable
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Tree select pins
  output logic             tree_select_bit2,
  output logic             tree_select_bit1,
  output logic             tree_select_bit0,
  // Channel select pins
  output logic             bank_channel_bit3,
  output logic             bank_channel_bit2,
  output logic             bank_channel_bit1,
  output logic             bank_channel_bit0,
  // Function relay coils
  output logic             relay_coil_bit0,
  output logic             relay_coil_bit1,
  output logic             relay_coil_bit2,
  output logic             relay_coil_bit3,
  output logic             relay_coil_bit4,
  output logic             relay_coil_bit5,
  // Status
  output logic             busy
);

  typedef enum logic {CS_IDLE, CS_PULSE} cmrs_coil_st_e;

  localparam int W = cmrs_pkg::CNT_W;

  // Bus pipeline
  logic                     wr_q;
  logic [7:0]               waddr_q;
  logic [31:0]              hrdata_q;
  logic                     hreadyout_q;
  logic                     hresp_q;

  // Block state
  cmrs_pkg::cmrs_pins_s     pins_q;
  cmrs_pkg::cmrs_cmd_s      cmd_q;
  logic [5:0]               last_coil_q;
  logic                     cfg_ss_q;
  logic                     busy_q;
  logic                     conflict_q;
  logic                     badchan_q;
  logic                     refused_q;
  cmrs_coil_st_e            coil_st_q;
  logic [W-1:0]             coil_cnt_q;
  logic [W-1:0]             settle_cnt_q;

  // Address phase decode
  wire        acc      = hsel & hready & htrans[1];
  wire        in_map   = (haddr[31:8] == 24'h000000) & (haddr[1:0] == 2'h0);
  wire [7:0]  raddr    = haddr[7:0];

  // Data phase write decode
  wire        cmd_wr   = wr_q & (waddr_q == cmrs_pkg::A_CMD);
  wire        coil_wr  = wr_q & (waddr_q == cmrs_pkg::A_COIL);
  wire        cfg_wr   = wr_q & (waddr_q == cmrs_pkg::A_CFG);
  wire        stat_wr  = wr_q & (waddr_q == cmrs_pkg::A_STAT);

  wire cmrs_pkg::cmrs_cmd_s cmd = cmrs_pkg::cmrs_cmd_s'(hwdata[7:0]);
  wire [5:0]  wcoil    = hwdata[5:0];

  wire        chan_ok  = (cmd.chan <= cmrs_pkg::CHAN_MAX) | (cmd.chan == cmrs_pkg::CHAN_NONE);
  wire        coil_bad = cmrs_pkg::clash(wcoil);

  wire        cmd_go   = ce & cmd_wr & ~busy_q & chan_ok;
  wire        coil_go  = ce & coil_wr & ~busy_q & ~coil_bad;

  wire [2:0]  new_tree = cmrs_pkg::tree_of(cmd.func, cmd.bank);
  wire [5:0]  new_coil = cmrs_pkg::coil_of(cmd.func);

  // Relays latch, so a pulse is only needed when the pattern moves
  wire        pulse_req = (cmd_go & (new_coil != last_coil_q)) |
                          (coil_go & (wcoil != cmrs_pkg::COIL_OFF));
  wire [5:0]  pulse_pat = coil_go ? wcoil : new_coil;

  wire        sw_change = cmd_go & ({new_tree, cmd.chan} != {pins_q.tree, pins_q.chan});

  // settle length by variant
  // Select outlasts deselect, so a swap only needs the select time
  wire [W-1:0] ss_len  = (cmd.chan == cmrs_pkg::CHAN_NONE) ? W'(SS_DES_CYC) : W'(SS_SEL_CYC);
  wire [W-1:0] settle_len = cfg_ss_q ? ss_len : W'(REED_CYC);

  wire        coil_stay   = (coil_st_q == CS_PULSE) & (coil_cnt_q != '0);
  wire        settle_stay = settle_cnt_q > W'(1);

  // Sticky flags: set wins over a write-one clear
  wire        conflict_set = ce & coil_wr & coil_bad;
  wire        badchan_set  = ce & cmd_wr & ~chan_ok;
  wire        refused_set  = ce & (cmd_wr | coil_wr) & busy_q;
  wire        clr_conflict = stat_wr & hwdata[cmrs_pkg::ST_CONFLICT];
  wire        clr_badchan  = stat_wr & hwdata[cmrs_pkg::ST_BADCHAN];
  wire        clr_refused  = stat_wr & hwdata[cmrs_pkg::ST_REFUSED];

  // Read selection
  wire [31:0] stat_word = {28'h0000000, refused_q, badchan_q, conflict_q, busy_q};
  wire [31:0] rd_word =
    !in_map                       ? 32'h00000000 :
    (raddr == cmrs_pkg::A_CMD)    ? {24'h000000, cmd_q} :
    (raddr == cmrs_pkg::A_COIL)   ? {26'h0000000, last_coil_q} :
    (raddr == cmrs_pkg::A_CFG)    ? {31'h00000000, cfg_ss_q} :
    (raddr == cmrs_pkg::A_STAT)   ? stat_word :
    (raddr == cmrs_pkg::A_OUT)    ? {19'h00000, pins_q} :
                                    32'h00000000;

  // Bus slave: zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q        <= 1'b0;
      waddr_q     <= 8'h00;
      hrdata_q    <= 32'h00000000;
      hreadyout_q <= 1'b0;
      hresp_q     <= 1'b0;
    end else begin
      wr_q        <= acc & hwrite & in_map;
      waddr_q     <= raddr;
      hrdata_q    <= (acc & ~hwrite) ? rd_word : 32'h00000000;
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
    end
  end

  // Configuration and sticky status
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_ss_q   <= 1'b0;
      conflict_q <= 1'b0;
      badchan_q  <= 1'b0;
      refused_q  <= 1'b0;
    end else if (ce) begin
      if (cfg_wr) begin
        cfg_ss_q <= hwdata[cmrs_pkg::CFG_SS_BIT];
      end
      conflict_q <= conflict_set | (conflict_q & ~clr_conflict);
      badchan_q  <= badchan_set | (badchan_q & ~clr_badchan);
      refused_q  <= refused_set | (refused_q & ~clr_refused);
    end
  end

  // All pins in one process: one driver for pins_q
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pins_q.tree <= cmrs_pkg::TREE_RST;
      pins_q.chan <= cmrs_pkg::CHAN_NONE;
      pins_q.coil <= cmrs_pkg::COIL_OFF;
      cmd_q       <= '0;
      last_coil_q <= cmrs_pkg::COIL_OFF;
      coil_cnt_q  <= '0;
      coil_st_q   <= CS_IDLE;
    end else if (ce) begin
      if (cmd_go) begin
        pins_q.tree <= new_tree;
        pins_q.chan <= cmd.chan;
        cmd_q       <= cmd;
      end
      case (coil_st_q)
        CS_IDLE: begin
          if (pulse_req) begin
            pins_q.coil <= pulse_pat;
            last_coil_q <= pulse_pat;
            coil_cnt_q  <= W'(COIL_CYC - 1);
            coil_st_q   <= CS_PULSE;
          end
        end
        CS_PULSE: begin
          if (coil_cnt_q == '0) begin
            pins_q.coil <= cmrs_pkg::COIL_OFF;
            coil_st_q   <= CS_IDLE;
          end else begin
            coil_cnt_q <= coil_cnt_q - W'(1);
          end
        end
        default: coil_st_q <= CS_IDLE;
      endcase
    end
  end

  // Switch settle counter and busy
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      settle_cnt_q <= '0;
      busy_q       <= 1'b0;
    end else if (ce) begin
      if (sw_change) begin
        settle_cnt_q <= settle_len;
      end else if (settle_cnt_q != '0) begin
        settle_cnt_q <= settle_cnt_q - W'(1);
      end
      busy_q <= pulse_req | sw_change | coil_stay | settle_stay;
    end
  end

  // Outputs straight from flops
  assign hrdata            = hrdata_q;
  assign hreadyout         = hreadyout_q;
  assign hresp             = hresp_q;
  assign tree_select_bit2  = pins_q.tree[2];
  assign tree_select_bit1  = pins_q.tree[1];
  assign tree_select_bit0  = pins_q.tree[0];
  assign bank_channel_bit3 = pins_q.chan[3];
  assign bank_channel_bit2 = pins_q.chan[2];
  assign bank_channel_bit1 = pins_q.chan[1];
  assign bank_channel_bit0 = pins_q.chan[0];
  assign relay_coil_bit0   = pins_q.coil[0];
  assign relay_coil_bit1   = pins_q.coil[1];
  assign relay_coil_bit2   = pins_q.coil[2];
  assign relay_coil_bit3   = pins_q.coil[3];
  assign relay_coil_bit4   = pins_q.coil[4];
  assign relay_coil_bit5   = pins_q.coil[5];
  assign busy              = busy_q;

  // Checks
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  wire lowv = (cmd.func != cmrs_pkg::FN_VDC_HI) & (cmd.func != cmrs_pkg::FN_RES4W);

  property p_tree_on;
    pins_q.tree != cmrs_pkg::TREE_OFF;
  endproperty
  a_tree_on: assert property (p_tree_on)
    else $error("tree select driven to deselected pattern");

  property p_coil_excl;
    !cmrs_pkg::clash(pins_q.coil);
  endproperty
  a_coil_excl: assert property (p_coil_excl)
    else $error("set and reset coil of one relay both on");

  property p_coil_end;
    (coil_st_q == CS_PULSE && coil_cnt_q == '0 && ce) |=> pins_q.coil == cmrs_pkg::COIL_OFF;
  endproperty
  a_coil_end: assert property (p_coil_end)
    else $error("coil bits not cleared at end of pulse");

  property p_coil_hold;
    (pins_q.coil != cmrs_pkg::COIL_OFF && coil_cnt_q != '0) |=> $stable(pins_q.coil);
  endproperty
  a_coil_hold: assert property (p_coil_hold)
    else $error("coil pattern changed before pulse time");

  property p_coil_busy;
    (pins_q.coil != cmrs_pkg::COIL_OFF) |-> busy_q;
  endproperty
  a_coil_busy: assert property (p_coil_busy)
    else $error("busy low while coils energized");

  property p_four_wire;
    (cmd_go && cmd.func == cmrs_pkg::FN_RES4W) |=> pins_q.tree == cmrs_pkg::TREE_4W;
  endproperty
  a_four_wire: assert property (p_four_wire)
    else $error("four-wire did not close both banks");

  property p_bank;
    (cmd_go && lowv) |=> pins_q.tree == ($past(cmd.bank) ? cmrs_pkg::TREE_HI : cmrs_pkg::TREE_LO);
  endproperty
  a_bank: assert property (p_bank)
    else $error("tree pattern does not match bank");

  property p_chan;
    cmd_go |=> pins_q.chan == $past(cmd.chan) && cmd_q.chan == pins_q.chan;
  endproperty
  a_chan: assert property (p_chan)
    else $error("channel bits not the commanded index");

  property p_chan_legal;
    pins_q.chan <= cmrs_pkg::CHAN_MAX || pins_q.chan == cmrs_pkg::CHAN_NONE;
  endproperty
  a_chan_legal: assert property (p_chan_legal)
    else $error("channel bits hold an illegal code");

  property p_settle;
    sw_change |=> busy_q && settle_cnt_q == $past(settle_len);
  endproperty
  a_settle: assert property (p_settle)
    else $error("settle wait not started after switch change");

  property p_ac_pattern;
    (cmd_go && pulse_req && cmd.func == cmrs_pkg::FN_VAC) |=> pins_q.coil == cmrs_pkg::COIL_AC;
  endproperty
  a_ac_pattern: assert property (p_ac_pattern)
    else $error("ac coil pattern wrong");

  property p_hv_tree;
    (cmd_go && cmd.func == cmrs_pkg::FN_VDC_HI) |=>
      pins_q.tree == ($past(cmd.bank) ? cmrs_pkg::TREE_HV_HI : cmrs_pkg::TREE_HV_LO);
  endproperty
  a_hv_tree: assert property (p_hv_tree)
    else $error("high-voltage dc tree pattern wrong");

  property p_reed_len;
    (sw_change && !cfg_ss_q) |=> settle_cnt_q == W'(REED_CYC);
  endproperty
  a_reed_len: assert property (p_reed_len)
    else $error("reed settle wait has the wrong length");

  property p_refuse_hold;
    (ce && cmd_wr && busy_q) |=> $stable(pins_q.tree) && $stable(pins_q.chan);
  endproperty
  a_refuse_hold: assert property (p_refuse_hold)
    else $error("command taken while busy");

  c_four_wire: cover property (cmd_go && cmd.func == cmrs_pkg::FN_RES4W);
  c_conflict:  cover property (conflict_set);
  c_deselect:  cover property (cmd_go && cmd.chan == cmrs_pkg::CHAN_NONE);
  c_pulse_end: cover property (coil_st_q == CS_PULSE ##1 coil_st_q == CS_IDLE);

endmodule // cmrs_top

/* File: verif/cmrs_coil_model.sv */
// Behavioural model of the function relays and tree switches
`timescale 1ns/1ps

module cmrs_coil_model #(
  parameter int COIL_CYC = 40
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Pins from the sequencer
  input  wire logic [2:0] tree,
  input  wire logic [5:0] coil,
  // Relay and bank state
  output logic      [2:0] pos,
  output logic      [1:0] banks,
  output logic      [7:0] faults
);
  logic [5:0] held_q;
  int         on_cnt_q;
  logic       bad;

  assign banks = tree[1:0];
  assign bad = (coil[0] & coil[1]) | (coil[2] & coil[3]) | (coil[4] & coil[5]) | (tree == 3'h0);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pos <= 3'h0;
      held_q <= 6'h00;
      on_cnt_q <= 0;
      faults <= 8'h00;
    end else begin
      if (coil != 6'h00) begin
        held_q <= coil;
        on_cnt_q <= on_cnt_q + 1;
      end else if (on_cnt_q != 0) begin
        on_cnt_q <= 0;
      end
      // pulse length
      // A short pulse leaves the armature where it was
      if (coil == 6'h00 && on_cnt_q != 0 && on_cnt_q >= COIL_CYC) begin
        pos <= {held_q[5], held_q[3], held_q[1]};
      end
      if (bad | (coil == 6'h00 && on_cnt_q != 0 && on_cnt_q < COIL_CYC)) begin
        faults <= faults + 8'h01;
      end
    end
  end
endmodule // cmrs_coil_model

/* File: verif/channel_mux_relay_sequencer_bench.sv */
// Self-checking bench for the channel mux and relay sequencer
`timescale 1ns/1ps

module channel_mux_relay_sequencer_bench;
  localparam int COIL = 40;
  localparam int REED = 20;
  localparam int SSEL = 15;
  localparam int SDES = 12;

  logic        hclk;
  logic        hresetn;
  logic        ce;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  wire  [31:0] hrdata;
  wire         hready;
  wire         hresp;
  wire  [2:0]  tree;
  wire  [3:0]  chan;
  wire  [5:0]  coil;
  wire         busy;
  wire  [2:0]  pos;
  wire  [1:0]  banks;
  wire  [7:0]  faults;
  int          err_total = 0;
  int          num_checks = 0;
  logic [31:0] rd;
  logic [5:0]  last_coil = 6'h00;

  cmrs_top #(.REED_CYC(REED), .SS_SEL_CYC(SSEL), .SS_DES_CYC(SDES), .COIL_CYC(COIL)) u_cmrs_top (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .tree_select_bit2(tree[2]),
    .tree_select_bit1(tree[1]), .tree_select_bit0(tree[0]), .bank_channel_bit3(chan[3]),
    .bank_channel_bit2(chan[2]), .bank_channel_bit1(chan[1]), .bank_channel_bit0(chan[0]),
    .relay_coil_bit0(coil[0]), .relay_coil_bit1(coil[1]), .relay_coil_bit2(coil[2]),
    .relay_coil_bit3(coil[3]), .relay_coil_bit4(coil[4]), .relay_coil_bit5(coil[5]),
    .busy(busy));

  cmrs_coil_model #(.COIL_CYC(COIL)) u_cmrs_coil_model (
    .clk(hclk), .rst_n(hresetn), .tree(tree), .coil(coil), .pos(pos), .banks(banks),
    .faults(faults));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("checks=%0d errors=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Single word transfer; read data lands in rd
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wait_idle();
    while (busy === 1'b1) @(posedge hclk);
    // One more edge so the relay model sees the coils drop
    @(posedge hclk);
    #1;
  endtask

  task automatic t_reset();
    chk(32'(tree), 32'h5);
    chk(32'(chan), 32'hf);
    chk(32'(coil), 32'h0);
    chk(32'(busy), 32'h0);
    bus(1'b0, 32'h8, 32'h0);
    chk(rd, 32'h0);
  endtask

  task automatic t_funcs();
    logic [5:0] ec;
    logic [2:0] et;
    logic [3:0] ch;
    logic       b;
    int         f;
    for (int i = 0; i < 10; i++) begin
      f = i % 8;
      b = (i >= 8) ^ i[0];
      ch = 4'(9 - i);
      ec = (f == 4 || f == 5) ? 6'h26 : (f == 2 || f == 3) ? 6'h19 : 6'h16;
      et = (f == 5) ? 3'h7 : (f == 1) ? (b ? 3'h2 : 3'h1) : (b ? 3'h6 : 3'h5);
      bus(1'b1, 32'h0, {24'h0, f[2:0], b, ch});
      #1;
      chk(32'(tree), 32'(et));
      chk(32'(chan), 32'(ch));
      chk(32'(busy), 32'h1);
      if (ec != last_coil) begin
        chk(32'(coil), 32'(ec));
        repeat (COIL - 1) @(posedge hclk);
        #1;
        chk(32'(coil), 32'(ec));
        @(posedge hclk);
        #1;
        chk(32'(coil), 32'h0);
      end else begin
        chk(32'(coil), 32'h0);
      end
      last_coil = ec;
      wait_idle();
      chk(32'(pos), 32'({ec[5], ec[3], ec[1]}));
      chk(32'(banks), (f == 5) ? 32'h3 : 32'({b, ~b}));
      bus(1'b0, 32'h10, 32'h0);
      chk(rd, {19'h0, et, ch, 6'h00});
    end
  endtask

  task automatic settle(input logic [31:0] cmd, input int n);
    bus(1'b1, 32'h0, cmd);
    repeat (n - 1) @(posedge hclk);
    #1;
    chk(32'(busy), 32'h1);
    @(posedge hclk);
    #1;
    chk(32'(busy), 32'h0);
  endtask

  // Same coil pattern as last pulse, so only the settle wait runs
  task automatic t_settle();
    settle(32'h03, REED);
    bus(1'b1, 32'h8, 32'h1);
    settle(32'h04, SSEL);
    settle(32'h0f, SDES);
    chk(32'(chan), 32'hf);
    bus(1'b1, 32'h8, 32'h0);
  endtask

  task automatic t_refuse();
    bus(1'b1, 32'h0, 32'h4a);
    #1;
    chk(32'({busy, chan, coil}), 32'({1'b0, 4'hf, 6'h00}));
    bus(1'b1, 32'h4, 32'h3);
    #1;
    chk(32'(coil), 32'h0);
    bus(1'b0, 32'hc, 32'h0);
    chk(rd, 32'h6);
    bus(1'b1, 32'hc, 32'he);
    bus(1'b1, 32'h4, 32'h19);
    #1;
    chk(32'(coil), 32'h19);
    bus(1'b1, 32'h0, 32'h05);
    bus(1'b0, 32'hc, 32'h0);
    chk(rd, 32'h9);
    chk(32'(chan), 32'hf);
    wait_idle();
    chk(32'({pos, coil}), 32'({3'h2, 6'h00}));
    bus(1'b1, 32'hc, 32'he);
    bus(1'b0, 32'h20, 32'h0);
    chk(rd, 32'h0);
    chk(32'(hresp), 32'h0);
  endtask

  // Low enable stretches the pulse and drops register writes
  task automatic t_freeze();
    bus(1'b1, 32'h4, 32'h26);
    ce <= 1'b0;
    bus(1'b1, 32'h8, 32'h1);
    bus(1'b0, 32'h8, 32'h0);
    chk(rd, 32'h0);
    repeat (COIL) @(posedge hclk);
    ce <= 1'b1;
    #1;
    chk(32'({busy, coil}), 32'({1'b1, 6'h26}));
    repeat (COIL - 1) @(posedge hclk);
    #1;
    chk(32'(coil), 32'h26);
    @(posedge hclk);
    #1;
    chk(32'(coil), 32'h0);
    wait_idle();
    chk(32'(pos), 32'h5);
  endtask

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // Whole run needs about 600 cycles
  initial begin
    repeat (20000) @(posedge hclk);
    err_total++;
    close_out();
  end

  initial begin
    hresetn = 1'b0;
    ce = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    #1;
    t_reset();
    t_funcs();
    t_settle();
    t_refuse();
    t_freeze();
    chk(32'(faults), 32'h0);
    close_out();
  end
endmodule // channel_mux_relay_sequencer_bench
